// [design/gss_pin_select.sv]
/*
 Pin status-output selector with AHB-Lite register slave and interrupt.
 Assumes all status sources are synchronous to hclk; completion inputs
 are one-cycle pulses.
*/
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module gss_pin_select
    import gss_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic spk_shutdown_hot,
    input wire logic spk_warning_hot,
    input wire logic underclock_err,
    input wire logic overclock_err,
    input wire logic [GSS_HP_CH-1:0] hp_seq_done,
    input wire logic [GSS_DSP_FLAGS-1:0] dsp_status_flag,
    output logic [GSS_PINS-1:0] pin_level,
    output logic irq
);

    // ==========================================================
    // Bus slave state
    logic [31:0] hrdata_q, hrdata_d;
    logic hreadyout_q;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [6:0] fsel_q [GSS_PINS];
    logic [6:0] fsel_d [GSS_PINS];
    logic [GSS_EVENTS-1:0] stat_q, stat_d;
    logic [GSS_EVENTS-1:0] en_q, en_d;
    logic irq_q, irq_d;
    logic [GSS_EVENTS-1:0] events;
    logic [GSS_EVENTS-1:0] clr_mask;
    logic [10:0] src_state;
    logic addr_ok;

    assign events = {overclock_err, underclock_err, hp_seq_done};
    assign src_state = {dsp_status_flag, overclock_err, underclock_err, spk_warning_hot, spk_shutdown_hot};
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        hrdata_d = 32'h0000_0000;
        wr_pend_d = addr_ok && hwrite;
        wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
        en_d = en_q;
        clr_mask = '0;
        for (int i = 0; i < GSS_PINS; i++) begin
            fsel_d[i] = fsel_q[i];
        end
        // Read data is latched in the address phase, shown in the data phase
        if (addr_ok && !hwrite) begin
            for (int i = 0; i < GSS_PINS; i++) begin
                if (haddr[7:0] == OFS_FSEL_BASE + 8'(4 * i)) begin
                    hrdata_d = {25'h0, fsel_q[i]};
                end
            end
            case (haddr[7:0])
                OFS_SRC_STATE: hrdata_d = {21'h0, src_state};
                OFS_IRQ_STATUS: hrdata_d = {24'h0, stat_q};
                OFS_IRQ_ENABLE: hrdata_d = {24'h0, en_q};
                default: ;
            endcase
        end
        if (wr_pend_q) begin
            for (int i = 0; i < GSS_PINS; i++) begin
                if (wr_addr_q == OFS_FSEL_BASE + 8'(4 * i)) begin
                    fsel_d[i] = hwdata[6:0];
                end
            end
            case (wr_addr_q)
                OFS_IRQ_CLEAR: clr_mask = hwdata[GSS_EVENTS-1:0];
                OFS_IRQ_ENABLE: en_d = hwdata[GSS_EVENTS-1:0];
                default: ;
            endcase
        end
        // A new event outweighs a clear in the same cycle
        stat_d = (stat_q & ~clr_mask) | events;
        irq_d = |(stat_d & en_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            stat_q <= '0;
            en_q <= IRQ_EN_RESET;
            irq_q <= 1'b0;
            for (int i = 0; i < GSS_PINS; i++) begin
                fsel_q[i] <= FSEL_RESET;
            end
        end else begin
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            stat_q <= stat_d;
            en_q <= en_d;
            irq_q <= irq_d;
            for (int i = 0; i < GSS_PINS; i++) begin
                fsel_q[i] <= fsel_d[i];
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign irq = irq_q;

    // ==========================================================
    // Per-pin status selection
    logic [3:0] cnt_q [GSS_PINS];
    logic [GSS_PINS-1:0] pin_q;

    genvar p;
    generate
        for (p = 0; p < GSS_PINS; p++) begin : gen_pin
            logic [3:0] cnt_d;
            logic pin_d;
            logic [6:0] hp_ofs;
            logic [6:0] dsp_ofs;
            logic is_hp;
            logic is_dsp;

            assign hp_ofs = fsel_q[p] - CODE_HP_FIRST;
            assign dsp_ofs = fsel_q[p] - CODE_DSP_FIRST;
            assign is_hp = fsel_q[p] >= CODE_HP_FIRST && fsel_q[p] <= CODE_HP_LAST;
            assign is_dsp = fsel_q[p] >= CODE_DSP_FIRST && fsel_q[p] <= CODE_DSP_LAST;

            always_comb begin
                cnt_d = 4'h0;
                if (is_hp) begin
                    if (hp_seq_done[hp_ofs[2:0]]) begin
                        cnt_d = PULSE_CYCLES;
                    end else if (cnt_q[p] != 4'h0) begin
                        cnt_d = cnt_q[p] - 4'h1;
                    end
                end
                case (fsel_q[p])
                    CODE_SPK_SHUTDOWN: pin_d = spk_shutdown_hot;
                    CODE_SPK_WARNING: pin_d = spk_warning_hot;
                    CODE_UNDERCLOCK: pin_d = underclock_err;
                    CODE_OVERCLOCK: pin_d = overclock_err;
                    default: begin
                        if (is_hp) begin
                            pin_d = cnt_d != 4'h0;
                        end else if (is_dsp) begin
                            // Every flag code shows its own flag
                            pin_d = dsp_status_flag[dsp_ofs[2:0]];
                        end else begin
                            pin_d = 1'b0;
                        end
                    end
                endcase
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q[p] <= 4'h0;
                    pin_q[p] <= 1'b0;
                end else begin
                    cnt_q[p] <= cnt_d;
                    pin_q[p] <= pin_d;
                end
            end
        end
    endgenerate

    assign pin_level = pin_q;

    // ==========================================================
    // Checks on pin 0
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_SHUTDOWN_FOLLOW: assert property (
        fsel_q[0] == CODE_SPK_SHUTDOWN |=> pin_level[0] == $past(spk_shutdown_hot))
        else $error("pin does not follow shutdown level");

    AST_WARNING_LOW: assert property (
        fsel_q[0] == CODE_SPK_WARNING && !spk_warning_hot |=> !pin_level[0])
        else $error("pin high without warning level");

    AST_WARNING_HIGH: assert property (
        fsel_q[0] == CODE_SPK_WARNING && spk_warning_hot |=> pin_level[0])
        else $error("pin low with warning level");

    AST_UNDERCLOCK: assert property (
        fsel_q[0] == CODE_UNDERCLOCK |=> pin_level[0] == $past(underclock_err))
        else $error("pin does not follow underclock error");

    AST_OVERCLOCK: assert property (
        (fsel_q[0] == CODE_OVERCLOCK && overclock_err) ##1 (fsel_q[0] == CODE_OVERCLOCK && !overclock_err)
        |-> pin_level[0] ##1 !pin_level[0])
        else $error("pin does not track overclock error");

    AST_HP_START: assert property (
        fsel_q[0] == CODE_HP_FIRST + 7'h2 && hp_seq_done[2] |=> pin_level[0] && cnt_q[0] == PULSE_CYCLES)
        else $error("completion pulse not started");

    AST_HP_END: assert property (
        fsel_q[0] == CODE_HP_LAST && cnt_q[0] == 4'h1 && hp_seq_done == '0 |=> !pin_level[0])
        else $error("completion pulse not ended");

    AST_HP_WIDTH: assert property (
        $rose(pin_level[0]) && fsel_q[0] == CODE_HP_FIRST && $stable(fsel_q[0]) && hp_seq_done == '0
        |-> pin_level[0] [*4])
        else $error("completion pulse too short");

    AST_DSP_FIRST: assert property (
        fsel_q[0] == CODE_DSP_FIRST |=> pin_level[0] == $past(dsp_status_flag[0]))
        else $error("pin does not follow first flag");

    AST_DSP_THREE: assert property (
        fsel_q[0] == CODE_DSP_FIRST + 7'h2 |=> pin_level[0] == $past(dsp_status_flag[2]))
        else $error("third flag code shows wrong level");

    AST_DSP_SEVEN: assert property (
        fsel_q[0] == CODE_DSP_LAST |=> pin_level[0] == $past(dsp_status_flag[6]))
        else $error("seventh flag code shows wrong flag");

endmodule : gss_pin_select

// [design/gss_pkg.sv]
/*
 Constants of the pin status-output selector: function-select codes,
 register offsets, reset values and pulse timing.
 Assumes a 250 MHz bus clock shared with every status source.
*/
package gss_pkg;

    // ==========================================================
    // Structure
    localparam int GSS_PINS = 2;
    localparam int GSS_HP_CH = 6;
    localparam int GSS_DSP_FLAGS = 7;
    localparam int GSS_EVENTS = 8;

    // ==========================================================
    // Function-select codes
    localparam logic [6:0] CODE_SPK_SHUTDOWN = 7'h2b;
    localparam logic [6:0] CODE_SPK_WARNING = 7'h2c;
    localparam logic [6:0] CODE_UNDERCLOCK = 7'h2d;
    localparam logic [6:0] CODE_OVERCLOCK = 7'h2e;
    localparam logic [6:0] CODE_HP_FIRST = 7'h2f;
    localparam logic [6:0] CODE_HP_LAST = 7'h34;
    localparam logic [6:0] CODE_DSP_FIRST = 7'h35;
    localparam logic [6:0] CODE_DSP_LAST = 7'h3b;
    localparam logic [6:0] FSEL_RESET = 7'h00;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_FSEL_BASE = 8'h00;
    localparam logic [7:0] OFS_SRC_STATE = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;

    // ==========================================================
    // Completion pulse timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_NS = 32;
    localparam logic [3:0] PULSE_CYCLES = 4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : gss_pkg

// [tb/gss_pin_watch.sv]
/*
 Host-side watcher of one status pin: counts rising edges and keeps
 the width in cycles of the last high run.
 Assumes the pin is sampled on rising edges of hclk.
*/
`timescale 1ns/1ps
module gss_pin_watch (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    output logic [7:0] rise_cnt,
    output logic [7:0] last_width
);
    // ==========================================================
    // Edge and width capture
    logic pin_q;
    logic [7:0] run_q;
    logic [7:0] rise_q;
    logic [7:0] width_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_q <= 1'b0;
            run_q <= 8'h00;
            rise_q <= 8'h00;
            width_q <= 8'h00;
        end else begin
            pin_q <= pin;
            run_q <= pin ? run_q + 8'h01 : 8'h00;
            if (pin && !pin_q) begin
                rise_q <= rise_q + 8'h01;
            end
            if (!pin && pin_q) begin
                width_q <= run_q;
            end
        end
    end
    assign rise_cnt = rise_q;
    assign last_width = width_q;
endmodule : gss_pin_watch

// [tb/tb_top.sv]
/*
 Self-checking bench of the pin status-output selector.
 Assumes zero-wait AHB-Lite slave and 250 MHz hclk.
*/
`timescale 1ns/1ps
module tb_top
    import gss_pkg::*;
;
    // ==========================================================
    // Signals
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [10:0] src;
    logic [5:0] hp_seq_done;
    logic [1:0] pin_level;
    logic [7:0] rise_cnt, last_width, n0;
    logic [6:0] code;
    logic [18:0] rows [24];
    int error_cnt = 0;
    int check_count = 0;

    gss_pin_select gss_pin_select_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .spk_shutdown_hot(src[0]),
        .spk_warning_hot(src[1]), .underclock_err(src[2]), .overclock_err(src[3]),
        .hp_seq_done(hp_seq_done), .dsp_status_flag(src[10:4]), .pin_level(pin_level), .irq(irq));
    gss_pin_watch gss_pin_watch_inst (.hclk(hclk), .hresetn(hresetn), .pin(pin_level[1]),
        .rise_cnt(rise_cnt), .last_width(last_width));

    // ==========================================================
    // Tasks
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            conclude();
        end
    endtask : wait_rdy
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0, d);
        chk(what, d, exp);
    endtask : rd_chk
    task automatic pulse(input int b);
        hp_seq_done <= 6'h01 << b;
        tick(1);
        hp_seq_done <= 6'h00;
        tick(12);
    endtask : pulse

    // ==========================================================
    // Clock and sequence
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        src = 11'h000;
        hp_seq_done = 6'h00;
        for (int i = 0; i < 11; i++) begin
            code = (i < 4) ? CODE_SPK_SHUTDOWN + 7'(i) : CODE_DSP_FIRST + 7'(i - 4);
            rows[2 * i] = {1'b1, code, 11'h001 << i};
            rows[2 * i + 1] = {1'b0, code, ~(11'h001 << i)};
        end
        rows[22] = {1'b0, 7'h2a, 11'h7ff};
        rows[23] = {1'b0, 7'h3c, 11'h7ff};
        tick(10);
        chk("ready_in_reset", hreadyout, 32'h0);
        chk("pins_in_reset", pin_level, 32'h0);
        hresetn <= 1'b1;
        tick(2);
        rd_chk("enable_reset", OFS_IRQ_ENABLE, 32'h0);
        $display("test reset done");
        foreach (rows[k]) begin
            src <= rows[k][10:0];
            wr(OFS_FSEL_BASE, 32'(rows[k][17:11]));
            tick(2);
            chk("pin0_level", pin_level[0], 32'(rows[k][18]));
        end
        $display("test level codes done");
        src <= 11'h000;
        for (int c = 0; c < 6; c++) begin
            wr(OFS_FSEL_BASE + 8'h04, 32'(CODE_HP_FIRST + 7'(c)));
            wr(OFS_FSEL_BASE, 32'(CODE_HP_FIRST + 7'(c)));
            tick(2);
            n0 = rise_cnt;
            pulse((c + 1) % 6);
            pulse(c);
            chk("hp_rises", 32'(rise_cnt - n0), 32'h1);
            chk("hp_width", last_width, 32'(PULSE_CYCLES));
        end
        $display("test headphone pulses done");
        rd_chk("irq_status", OFS_IRQ_STATUS, 32'hff);
        chk("irq_masked", irq, 32'h0);
        wr(OFS_IRQ_ENABLE, 32'h80);
        tick(2);
        chk("irq_enabled", irq, 32'h1);
        wr(OFS_IRQ_CLEAR, 32'hff);
        tick(2);
        rd_chk("irq_cleared", OFS_IRQ_STATUS, 32'h0);
        chk("irq_off", irq, 32'h0);
        src <= 11'h008;
        tick(2);
        rd_chk("src_state", OFS_SRC_STATE, 32'h8);
        chk("irq_event", irq, 32'h1);
        wr(OFS_IRQ_CLEAR, 32'h80);
        rd_chk("clear_loses_to_event", OFS_IRQ_STATUS, 32'h80);
        wr(OFS_IRQ_ENABLE, 32'h0);
        tick(2);
        chk("irq_mask", irq, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        chk("hresp_okay", hresp, 32'h0);
        $display("test interrupt done");
        wr(OFS_FSEL_BASE, 32'(CODE_OVERCLOCK));
        tick(2);
        chk("pin0_before_reset", pin_level[0], 32'h1);
        hresetn <= 1'b0;
        tick(2);
        chk("pins_reset_again", pin_level, 32'h0);
        hresetn <= 1'b1;
        tick(2);
        rd_chk("sel_reset", OFS_FSEL_BASE, 32'h0);
        $display("test second reset done");
        conclude();
    end
endmodule : tb_top
